// >>> core/wfd_pkg.sv
// package: register map, field positions, reset values and constants of the wake detector
package wfd_pkg;
  // apb byte addresses
  localparam logic [7:0] ADDR_WAKE_CTRL_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK         = 8'h04;
  localparam logic [7:0] ADDR_IRQ_SOURCE       = 8'h08;
  localparam logic [7:0] ADDR_FILTER_CFG_LO    = 8'h0C;
  localparam logic [7:0] ADDR_FILTER_CFG_HI    = 8'h10;
  localparam logic [7:0] ADDR_WAKE_ADDR_WORD0  = 8'h14;
  localparam logic [7:0] ADDR_WAKE_ADDR_WORD1  = 8'h18;
  localparam logic [7:0] ADDR_WAKE_ADDR_WORD2  = 8'h1C;
  localparam logic [7:0] ADDR_MASK_BASE        = 8'h20;
  localparam int         MASK_WORDS            = 4;
  // wake_ctrl_status fields
  localparam int BIT_EXACT_EN   = 0;
  localparam int BIT_BCAST_EN   = 1;
  localparam int BIT_MAGIC_EN   = 2;
  localparam int BIT_PATTERN_EN = 3;
  localparam int BIT_EXACT_SEEN = 4;
  localparam int BIT_BCAST_SEEN = 5;
  localparam int BIT_MAGIC_SEEN = 6;
  localparam int BIT_PATT_SEEN  = 7;
  // interrupt mask/source wake bit
  localparam int BIT_WAKE_IRQ   = 8;
  // filter_cfg_lo fields
  localparam int BIT_FLT_EN       = 31;
  localparam int BIT_FLT_TRIG     = 30;
  localparam int BIT_FLT_BCAST    = 26;
  localparam int BIT_FLT_MCAST    = 25;
  localparam int BIT_FLT_ADDR     = 24;
  localparam int FLT_OFFSET_LSB   = 0;
  localparam int FLT_OFFSET_W     = 8;
  // crc and magic constants
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [47:0] SYNC_WORD  = 48'hFFFF_FFFF_FFFF;
  localparam int          MAGIC_REPS = 16;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // byte positions
  localparam logic [10:0] DA_LAST_BYTE = 11'h005;
  localparam logic [10:0] SA_LAST_BYTE = 11'h00B;
endpackage

// >>> core/wfd_crc16.sv
// combinational single-byte update of the filter crc-16
`timescale 1ns/1ps
module wfd_crc16
  import wfd_pkg::*;
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  logic [7:0] f;

  // chained intermediate terms
  always_comb begin
    f[0] = crc_in[15] ^ data_in[0];
    for (int i = 1; i < 8; i++) begin
      f[i] = crc_in[15-i] ^ f[i-1] ^ data_in[i];
    end
  end

  // new crc from old crc and terms
  always_comb begin
    crc_out[15]    = crc_in[7] ^ f[7];
    crc_out[14:10] = crc_in[6:2];
    crc_out[9]     = crc_in[1] ^ f[0];
    crc_out[8]     = crc_in[0] ^ f[1];
    for (int k = 2; k < 8; k++) begin
      crc_out[k] = f[7-k] ^ f[9-k];
    end
    crc_out[1] = f[6];
    crc_out[0] = f[7];
  end
endmodule

// >>> core/wfd_magic.sv
// magic packet scanner: sync run of ff bytes then sixteen address copies
`timescale 1ns/1ps
module wfd_magic
  import wfd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        frame_start,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic [47:0] wake_addr,
  output logic             found
);
  logic [2:0] ff_run_reg;
  logic       synced_reg;
  logic [2:0] pos_reg;
  logic [4:0] reps_reg;
  logic [7:0] exp_byte;
  logic       byte_ok;

  // expected byte of the address copy, first byte on the wire first
  always_comb begin
    exp_byte = wake_addr[8*pos_reg +: 8];
    byte_ok  = (byte_data == exp_byte);
  end

  // scanner; a broken copy falls back to sync search
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ff_run_reg <= 3'h0;
      synced_reg <= 1'b0;
      pos_reg    <= 3'h0;
      reps_reg   <= 5'h00;
      found      <= 1'b0;
    end else if (frame_start) begin
      ff_run_reg <= 3'h0;
      synced_reg <= 1'b0;
      pos_reg    <= 3'h0;
      reps_reg   <= 5'h00;
      found      <= 1'b0;
    end else if (byte_valid && !found) begin
      if (synced_reg && byte_ok) begin
        if (pos_reg == 3'h5) begin
          pos_reg  <= 3'h0;
          reps_reg <= reps_reg + 5'h01;
          if (reps_reg == 5'(MAGIC_REPS - 1)) begin
            found <= 1'b1;
          end
        end else begin
          pos_reg <= pos_reg + 3'h1;
        end
      end else begin
        // restart: rescan for sync in the rest of the frame
        pos_reg  <= 3'h0;
        reps_reg <= 5'h00;
        if (byte_data == 8'hFF) begin
          // a run of six ff bytes arms the copy counter anywhere
          if (ff_run_reg >= 3'h5) begin
            synced_reg <= 1'b1;
            ff_run_reg <= 3'h6;
          end else begin
            synced_reg <= 1'b0;
            ff_run_reg <= ff_run_reg + 3'h1;
          end
        end else begin
          synced_reg <= 1'b0;
          ff_run_reg <= 3'h0;
        end
      end
      if (synced_reg && byte_ok && byte_data != 8'hFF) begin
        ff_run_reg <= 3'h0;
      end
    end
  end
endmodule

// >>> core/wfd_top.sv
// wake frame detector: apb registers, receive byte stream inspection, wake outputs
//
// Contract
// - exact-address wake flags frames whose destination equals the programmed address.
// - broadcast wake flags frames with all-ones destination.
// - only frames passing check sequence and length may wake.
// - a match sets wake source flag, per-type status, gated interrupt.
// - magic needs unicast-to-us or broadcast, sync then sixteen address copies.
// - broken copies restart the sync search in the rest of frame.
// - sync and copies may sit anywhere; copies need preceding sync. The scanner only sees bytes after the source address.
// - 128-bit byte mask selects bytes offset plus j for the crc.
// - pattern offset counts from zero at first destination byte.
// - filter crc starts all ones each frame, updates on selected bytes.
// - intermediate terms chain crc bits, previous term and data bits.
// - high crc byte follows the given xor equations.
// - low crc byte follows the given xor equations.
// - after the window the crc is compared with the expected value.
// - filter address qualification ors exact, any-multicast and broadcast.
// - pattern wake needs filter on, crc match and frame-type address case.
// - filter checked only when pattern wake on; pass sets pattern status.
// - wake output stays asserted until the four status bits are cleared.
// - interrupt output stays asserted until software clears the source; the code also releases it when the wake interrupt mask bit is cleared.
// - wake registers cleared only by hardware reset, not soft reset.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module wfd_top
  import wfd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_sof,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_eof,
  input  wire logic        rx_fcs_ok,
  input  wire logic        rx_len_ok,
  output logic             irq_out_n,
  output logic             wake_event_out_n
);
  logic        rst_meta_reg;
  logic        rst_n;
  logic [3:0]  wake_enables_reg;
  logic [3:0]  wake_seen_reg;
  logic        irq_mask_reg;
  logic        irq_src_reg;
  logic [31:0] filter_cfg_lo_reg;
  logic [15:0] filter_crc_exp_reg;
  logic [31:0] wake_addr_reg [3];
  logic [31:0] mask_reg [MASK_WORDS];
  logic [47:0] wake_addr;
  logic [127:0] mask_flat;
  logic [10:0] byte_idx_reg;
  logic [15:0] crc_reg;
  logic [15:0] crc_next;
  logic        da_exact_reg;
  logic        da_bcast_reg;
  logic        da_mcast_reg;
  logic        magic_found;
  logic [10:0] rel_idx;
  logic        in_window;
  logic        sel_byte;
  logic        wr_en;
  logic        rd_en;
  logic        frame_good;
  logic        hit_exact;
  logic        hit_bcast;
  logic        hit_magic;
  logic        hit_patt;
  logic        addr_qual;
  logic [3:0]  hit_vec;
  logic [3:0]  seen_clear;
  logic        trig_clear;

  // address word decode used by the write, clear and trigger decodes; the read mux uses its own case
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // apb: zero wait states, no errors
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;

  // wake address: word0 low 32 bits, word1 high 16 bits; first wire byte in bits 7:0
  assign wake_addr = {wake_addr_reg[1][15:0], wake_addr_reg[0]};

  // flat byte mask from mask words
  genvar g;
  generate
    for (g = 0; g < MASK_WORDS; g++) begin : g_mask
      assign mask_flat[32*g +: 32] = mask_reg[g];
    end
  endgenerate

  // configuration registers, hardware reset only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_enables_reg   <= 4'h0;
      irq_mask_reg       <= 1'b0;
      filter_crc_exp_reg <= 16'h0000;
      for (int i = 0; i < 3; i++) begin
        wake_addr_reg[i] <= RESET_ZERO;
      end
      for (int i = 0; i < MASK_WORDS; i++) begin
        mask_reg[i] <= RESET_ZERO;
      end
    end else if (wr_en) begin
      if (addr_is(paddr, ADDR_WAKE_CTRL_STATUS)) begin
        wake_enables_reg <= pwdata[BIT_PATTERN_EN:BIT_EXACT_EN];
      end
      if (addr_is(paddr, ADDR_IRQ_MASK)) begin
        irq_mask_reg <= pwdata[BIT_WAKE_IRQ];
      end
      if (addr_is(paddr, ADDR_FILTER_CFG_HI)) begin
        filter_crc_exp_reg <= pwdata[15:0];
      end
      if (addr_is(paddr, ADDR_WAKE_ADDR_WORD0)) begin
        wake_addr_reg[0] <= pwdata;
      end
      if (addr_is(paddr, ADDR_WAKE_ADDR_WORD1)) begin
        wake_addr_reg[1] <= {16'h0000, pwdata[15:0]};
      end
      if (addr_is(paddr, ADDR_WAKE_ADDR_WORD2)) begin
        wake_addr_reg[2] <= RESET_ZERO;
      end
      for (int i = 0; i < MASK_WORDS; i++) begin
        if (addr_is(paddr, ADDR_MASK_BASE + 8'(4 * i))) begin
          mask_reg[i] <= pwdata;
        end
      end
    end
  end

  // filter_cfg_lo: config bits written, trigger bit sticky with set over clear
  assign trig_clear = wr_en && addr_is(paddr, ADDR_FILTER_CFG_LO) && pwdata[BIT_FLT_TRIG];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      filter_cfg_lo_reg <= RESET_ZERO;
    end else begin
      if (wr_en && addr_is(paddr, ADDR_FILTER_CFG_LO)) begin
        filter_cfg_lo_reg[BIT_FLT_EN]    <= pwdata[BIT_FLT_EN];
        filter_cfg_lo_reg[BIT_FLT_BCAST] <= pwdata[BIT_FLT_BCAST];
        filter_cfg_lo_reg[BIT_FLT_MCAST] <= pwdata[BIT_FLT_MCAST];
        filter_cfg_lo_reg[BIT_FLT_ADDR]  <= pwdata[BIT_FLT_ADDR];
        filter_cfg_lo_reg[FLT_OFFSET_LSB +: FLT_OFFSET_W] <=
          pwdata[FLT_OFFSET_LSB +: FLT_OFFSET_W];
      end
      if (hit_patt) begin
        filter_cfg_lo_reg[BIT_FLT_TRIG] <= 1'b1;
      end else if (trig_clear) begin
        filter_cfg_lo_reg[BIT_FLT_TRIG] <= 1'b0;
      end
    end
  end

  // byte position counter, zero at first destination byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      byte_idx_reg <= 11'h000;
    end else if (rx_sof) begin
      byte_idx_reg <= 11'h000;
    end else if (rx_valid && byte_idx_reg != 11'h7FF) begin
      byte_idx_reg <= byte_idx_reg + 11'h001;
    end
  end

  // destination address classification per byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      da_exact_reg <= 1'b0;
      da_bcast_reg <= 1'b0;
      da_mcast_reg <= 1'b0;
    end else if (rx_sof) begin
      da_exact_reg <= 1'b1;
      da_bcast_reg <= 1'b1;
      da_mcast_reg <= 1'b0;
    end else if (rx_valid && byte_idx_reg <= DA_LAST_BYTE) begin
      if (rx_data != wake_addr[8*byte_idx_reg[2:0] +: 8]) begin
        da_exact_reg <= 1'b0;
      end
      if (rx_data != 8'hFF) begin
        da_bcast_reg <= 1'b0;
      end
      if (byte_idx_reg == 11'h000) begin
        da_mcast_reg <= rx_data[0];
      end
    end
  end

  // filter window and crc
  assign rel_idx   = byte_idx_reg - 11'(filter_cfg_lo_reg[FLT_OFFSET_LSB +: FLT_OFFSET_W]);
  assign in_window = byte_idx_reg >= 11'(filter_cfg_lo_reg[FLT_OFFSET_LSB +: FLT_OFFSET_W])
                     && rel_idx < 11'h080;
  assign sel_byte  = rx_valid && in_window && mask_flat[rel_idx[6:0]];

  wfd_crc16 u_crc (
    .crc_in  (crc_reg),
    .data_in (rx_data),
    .crc_out (crc_next)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= CRC_INIT;
    end else if (rx_sof) begin
      crc_reg <= CRC_INIT;
    end else if (sel_byte) begin
      crc_reg <= crc_next;
    end
  end

  wfd_magic u_magic (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .frame_start (rx_sof),
    .byte_valid  (rx_valid && byte_idx_reg > SA_LAST_BYTE),
    .byte_data   (rx_data),
    .wake_addr   (wake_addr),
    .found       (magic_found)
  );

  // frame end qualification
  assign frame_good = rx_eof && rx_fcs_ok && rx_len_ok;
  assign addr_qual  = (filter_cfg_lo_reg[BIT_FLT_ADDR] && da_exact_reg)
                      || (filter_cfg_lo_reg[BIT_FLT_MCAST] && da_mcast_reg && !da_bcast_reg)
                      || (filter_cfg_lo_reg[BIT_FLT_BCAST] && da_bcast_reg);
  assign hit_exact  = frame_good && wake_enables_reg[BIT_EXACT_EN] && da_exact_reg;
  assign hit_bcast  = frame_good && wake_enables_reg[BIT_BCAST_EN] && da_bcast_reg;
  assign hit_magic  = frame_good && wake_enables_reg[BIT_MAGIC_EN] && magic_found
                      && (da_exact_reg || da_bcast_reg);
  // unicast passes with address check off; multicast/broadcast by their options
  assign hit_patt   = frame_good && wake_enables_reg[BIT_PATTERN_EN]
                      && filter_cfg_lo_reg[BIT_FLT_EN]
                      && (crc_reg == filter_crc_exp_reg)
                      && ((!da_mcast_reg && (!filter_cfg_lo_reg[BIT_FLT_ADDR] || addr_qual))
                          || (da_mcast_reg && addr_qual));
  assign hit_vec    = {hit_patt, hit_magic, hit_bcast, hit_exact};

  // sticky per-type status, set wins over write-one clear
  assign seen_clear = (wr_en && addr_is(paddr, ADDR_WAKE_CTRL_STATUS))
                      ? pwdata[BIT_PATT_SEEN:BIT_EXACT_SEEN] : 4'h0;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_seen_reg <= 4'h0;
    end else begin
      wake_seen_reg <= (wake_seen_reg & ~seen_clear) | hit_vec;
    end
  end

  // wake source flag, write-one clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_src_reg <= 1'b0;
    end else if (|hit_vec) begin
      irq_src_reg <= 1'b1;
    end else if (wr_en && addr_is(paddr, ADDR_IRQ_SOURCE) && pwdata[BIT_WAKE_IRQ]) begin
      irq_src_reg <= 1'b0;
    end
  end

  // active-low outputs from flip-flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_n        <= 1'b1;
      wake_event_out_n <= 1'b1;
    end else begin
      irq_out_n        <= !(irq_src_reg && irq_mask_reg);
      wake_event_out_n <= !(|wake_seen_reg);
    end
  end

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        ADDR_WAKE_CTRL_STATUS: prdata[7:0] = {wake_seen_reg, wake_enables_reg};
        ADDR_IRQ_MASK:         prdata[BIT_WAKE_IRQ] = irq_mask_reg;
        ADDR_IRQ_SOURCE:       prdata[BIT_WAKE_IRQ] = irq_src_reg;
        ADDR_FILTER_CFG_LO:    prdata = filter_cfg_lo_reg;
        ADDR_FILTER_CFG_HI:    prdata[15:0] = filter_crc_exp_reg;
        ADDR_WAKE_ADDR_WORD0:  prdata = wake_addr_reg[0];
        ADDR_WAKE_ADDR_WORD1:  prdata = wake_addr_reg[1];
        ADDR_WAKE_ADDR_WORD2:  prdata = wake_addr_reg[2];
        ADDR_MASK_BASE:          prdata = mask_reg[0];
        ADDR_MASK_BASE + 8'h04:  prdata = mask_reg[1];
        ADDR_MASK_BASE + 8'h08:  prdata = mask_reg[2];
        ADDR_MASK_BASE + 8'h0C:  prdata = mask_reg[3];
        default:               prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule

// >>> testbench/wfd_chk.sv
// concurrent checks on the wake detector ports
`timescale 1ns/1ps
module wfd_chk
  import wfd_pkg::*;
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        rx_eof,
  input wire logic        rx_fcs_ok,
  input wire logic        rx_len_ok,
  input wire logic        irq_out_n,
  input wire logic        wake_event_out_n
);
  logic       wr_hit;
  logic       rd_sts;
  logic       rd_src;
  logic [3:0] en_shadow;
  logic       mask_shadow;
  logic       bad_eof;
  // decoded bus accesses and failed frame ends
  assign wr_hit  = psel & penable & pwrite;
  assign rd_sts  = psel & penable & ~pwrite & (paddr == ADDR_WAKE_CTRL_STATUS);
  assign rd_src  = psel & penable & ~pwrite & (paddr == ADDR_IRQ_SOURCE);
  assign bad_eof = rx_eof & ~(rx_fcs_ok & rx_len_ok);
  // shadow copies of enables and wake interrupt mask as written
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_shadow   <= 4'h0;
      mask_shadow <= 1'b0;
    end else if (wr_hit && paddr == ADDR_WAKE_CTRL_STATUS) begin
      en_shadow <= pwdata[3:0];
    end else if (wr_hit && paddr == ADDR_IRQ_MASK) begin
      mask_shadow <= pwdata[BIT_WAKE_IRQ];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wake_at_eof_a: assert property ($fell(wake_event_out_n) |-> $past(rx_eof, 2))
    else $error("wake output fell without a frame end");
  wake_enabled_a: assert property ($fell(wake_event_out_n) |-> $past(en_shadow != 4'h0, 2))
    else $error("wake output fell with all wake types off");
  bad_wake_a: assert property (bad_eof && wake_event_out_n |-> ##2 wake_event_out_n)
    else $error("failed frame raised the wake output");
  bad_irq_a: assert property (bad_eof && irq_out_n && !psel ##1 !psel |=> irq_out_n)
    else $error("failed frame raised the interrupt");
  irq_gate_a: assert property (rd_src && $past(psel && paddr == ADDR_IRQ_SOURCE)
    && $stable(prdata[BIT_WAKE_IRQ]) && $stable(mask_shadow)
    |-> irq_out_n == !(prdata[BIT_WAKE_IRQ] && mask_shadow))
    else $error("interrupt pin disagrees with source and mask");
  wake_tracks_a: assert property (rd_sts && $past(psel && paddr == ADDR_WAKE_CTRL_STATUS)
    && $stable(prdata[7:4]) |-> wake_event_out_n == (prdata[7:4] == 4'h0))
    else $error("wake pin disagrees with seen bits");
  irq_holds_a: assert property ($rose(irq_out_n) |-> $past(wr_hit, 2))
    else $error("interrupt released without a write");
  wake_holds_a: assert property ($rose(wake_event_out_n)
    |-> $past(wr_hit && paddr == ADDR_WAKE_CTRL_STATUS, 2))
    else $error("wake output released without status write");
endmodule
bind wfd_top wfd_chk chk_inst (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .rx_eof, .rx_fcs_ok, .rx_len_ok, .irq_out_n, .wake_event_out_n);

// >>> testbench/wfd_station.sv
// remote station model feeding received frames byte by byte
`timescale 1ns/1ps
module wfd_station
(
  input  wire logic       mclk,
  output logic            rx_sof,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_eof,
  output logic            rx_fcs_ok,
  output logic            rx_len_ok
);
  logic [7:0] frame [0:255];
  // idle lines and default payload
  initial begin
    rx_sof = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_eof = 1'b0;
    rx_fcs_ok = 1'b0;
    rx_len_ok = 1'b0;
    for (int i = 0; i < 256; i++) frame[i] = 8'(i * 7 + 3);
  end
  // start pulse, bytes with optional idle gaps, end pulse with check results
  task automatic send(input int len, input logic fcs, input logic lok, input int gap);
    rx_sof <= 1'b1;
    @(posedge mclk);
    rx_sof <= 1'b0;
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_data <= frame[i];
      @(posedge mclk);
      repeat (gap) begin
        rx_valid <= 1'b0;
        rx_data <= ~frame[i];  // no stale byte between strobes
        @(posedge mclk);
      end
    end
    rx_valid <= 1'b0;
    rx_data <= ~frame[len - 1];
    rx_eof <= 1'b1;
    rx_fcs_ok <= fcs;
    rx_len_ok <= lok;
    @(posedge mclk);
    rx_eof <= 1'b0;
    rx_fcs_ok <= ~fcs;
    rx_len_ok <= ~lok;
  endtask
endmodule

// >>> testbench/wfd_top_bench.sv
// self-checking bench for the wake frame detector
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end
module wfd_top_bench
  import wfd_pkg::*;
;
  localparam logic [47:0] MY_ADDR = 48'h6655_4433_2210;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err_seen;
  logic        rx_sof;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_eof;
  logic        rx_fcs_ok;
  logic        rx_len_ok;
  logic        irq_out_n;
  logic        wake_event_out_n;
  logic [31:0] rd;
  int          fails = 0;
  int          comparisons = 0;
  int          gap = 0;
  wfd_top u_wfd_top (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_sof, .rx_valid, .rx_data, .rx_eof, .rx_fcs_ok, .rx_len_ok,
    .irq_out_n, .wake_event_out_n);
  wfd_station station (.mclk, .rx_sof, .rx_valid, .rx_data, .rx_eof, .rx_fcs_ok, .rx_len_ok);
  // clock
  always #5 mclk = ~mclk;
  // one bus transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) fails++;
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(nm, exp, rd)
    `CHK({nm, " error"}, 1'b0, err_seen)
  endtask
  task automatic put(input int pos, input logic [47:0] v);
    for (int i = 0; i < 6; i++) station.frame[pos + i] = v[8 * i +: 8];
  endtask
  // reference filter crc over the station frame
  function automatic logic [15:0] crc_of(input int off, input logic [127:0] m);
    logic [15:0] c;
    logic [7:0]  f;
    logic [7:0]  d;
    c = CRC_INIT;
    for (int j = 0; j < 128; j++) begin
      if (m[j]) begin
        d = station.frame[off + j];
        f[0] = c[15] ^ d[0];
        for (int i = 1; i < 8; i++) f[i] = c[15 - i] ^ f[i - 1] ^ d[i];
        c = {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1], f[0] ^ f[2], f[1] ^ f[3],
             f[2] ^ f[4], f[3] ^ f[5], f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
      end
    end
    return c;
  endfunction
  // send a frame, expect the seen bits and pins, then clear them
  task automatic frame_chk(input string nm, input int len, input logic fcs, input logic lok,
                           input logic [3:0] seen, input logic [3:0] en);
    station.send(len, fcs, lok, gap);
    repeat (3) @(posedge mclk);
    `CHK({nm, " wake pin"}, seen == 4'h0, wake_event_out_n)
    `CHK({nm, " irq pin"}, seen == 4'h0, irq_out_n)
    rdchk({nm, " status"}, ADDR_WAKE_CTRL_STATUS, {24'h0, seen, en});
    rdchk({nm, " source"}, ADDR_IRQ_SOURCE, {23'h0, seen != 4'h0, 8'h0});
    apb(1'b1, ADDR_WAKE_CTRL_STATUS, {24'h0, 4'hF, en});
    apb(1'b1, ADDR_IRQ_SOURCE, 32'h0000_0100);
    @(posedge mclk);
    `CHK({nm, " released"}, 1'b1, irq_out_n & wake_event_out_n)
    $display("frame %s done", nm);
  endtask
  task automatic t_regs;
    for (int a = 0; a <= 8'h30; a += 4) rdchk("reset value", 8'(a), 32'h0);
    $display("test regs done");
  endtask
  task automatic t_exact;
    apb(1'b1, ADDR_WAKE_ADDR_WORD0, MY_ADDR[31:0]);
    apb(1'b1, ADDR_WAKE_ADDR_WORD1, {16'h0, MY_ADDR[47:32]});
    apb(1'b1, ADDR_WAKE_CTRL_STATUS, 32'h0000_0001);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0100);
    rdchk("addr hi", ADDR_WAKE_ADDR_WORD1, {16'h0, MY_ADDR[47:32]});
    put(0, MY_ADDR);
    frame_chk("bad fcs", 20, 1'b0, 1'b1, 4'h0, 4'h1);
    frame_chk("bad len", 20, 1'b1, 1'b0, 4'h0, 4'h1);
    frame_chk("exact", 20, 1'b1, 1'b1, 4'h1, 4'h1);
    $display("test exact done");
  endtask
  task automatic t_bcast;
    apb(1'b1, ADDR_WAKE_CTRL_STATUS, 32'h0000_0002);
    frame_chk("not bcast", 20, 1'b1, 1'b1, 4'h0, 4'h2);
    put(0, SYNC_WORD);
    frame_chk("bcast", 20, 1'b1, 1'b1, 4'h2, 4'h2);
    $display("test bcast done");
  endtask
  task automatic t_magic;
    apb(1'b1, ADDR_WAKE_CTRL_STATUS, 32'h0000_0004);
    put(12, SYNC_WORD);
    for (int k = 0; k < 3; k++) put(18 + 6 * k, MY_ADDR);
    station.frame[36] = 8'h00;
    put(37, SYNC_WORD);
    for (int k = 0; k < 15; k++) put(43 + 6 * k, MY_ADDR);
    put(133, 48'h0);
    frame_chk("fifteen", 140, 1'b1, 1'b1, 4'h0, 4'h4);
    put(133, MY_ADDR);
    gap = 1;
    frame_chk("magic", 140, 1'b1, 1'b1, 4'h4, 4'h4);
    gap = 0;
    put(0, 48'h0000_0000_0002);
    frame_chk("magic other", 140, 1'b1, 1'b1, 4'h0, 4'h4);
    $display("test magic done");
  endtask
  task automatic t_pattern;
    logic [15:0] c;
    c = crc_of(3, 128'h205);
    apb(1'b1, ADDR_MASK_BASE, 32'h0000_0205);
    apb(1'b1, ADDR_FILTER_CFG_HI, {16'h0, c ^ 16'h0001});
    apb(1'b1, ADDR_FILTER_CFG_LO, 32'h8000_0003);
    apb(1'b1, ADDR_WAKE_CTRL_STATUS, 32'h0000_0008);
    frame_chk("crc off", 40, 1'b1, 1'b1, 4'h0, 4'h8);
    apb(1'b1, ADDR_FILTER_CFG_HI, {16'h0, c});
    frame_chk("pattern", 40, 1'b1, 1'b1, 4'h8, 4'h8);
    rdchk("triggered", ADDR_FILTER_CFG_LO, 32'hC000_0003);
    apb(1'b1, ADDR_FILTER_CFG_LO, 32'hC000_0003);
    rdchk("trig clear", ADDR_FILTER_CFG_LO, 32'h8000_0003);
    put(0, 48'h0000_0000_0001);
    frame_chk("mcast off", 40, 1'b1, 1'b1, 4'h0, 4'h8);
    apb(1'b1, ADDR_FILTER_CFG_LO, 32'h8200_0003);
    frame_chk("mcast on", 40, 1'b1, 1'b1, 4'h8, 4'h8);
    // specific address option: foreign multicast refused, our unicast accepted
    apb(1'b1, ADDR_FILTER_CFG_LO, 32'h8100_0003);
    frame_chk("addr miss", 40, 1'b1, 1'b1, 4'h0, 4'h8);
    put(0, MY_ADDR);
    apb(1'b1, ADDR_FILTER_CFG_HI, {16'h0, crc_of(3, 128'h205)});
    frame_chk("addr hit", 40, 1'b1, 1'b1, 4'h8, 4'h8);
    // broadcast frame needs its own option
    put(0, SYNC_WORD);
    apb(1'b1, ADDR_FILTER_CFG_HI, {16'h0, crc_of(3, 128'h205)});
    frame_chk("bcast off", 40, 1'b1, 1'b1, 4'h0, 4'h8);
    apb(1'b1, ADDR_FILTER_CFG_LO, 32'h8400_0003);
    frame_chk("bcast on", 40, 1'b1, 1'b1, 4'h8, 4'h8);
    $display("test pattern done");
  endtask
  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    conclude();
  end
  // reset, then the scenarios
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_regs();
    t_exact();
    t_bcast();
    t_magic();
    t_pattern();
    conclude();
  end
endmodule
